/* File: common/dacc_pkg.sv */
// Shared constants for the dual converter channel configuration block.
// Assumes 16-bit configuration words placed in the low half of a 32-bit bus word.
package dacc_pkg;

    // ==================================================================
    // Register map
    localparam int DACC_DATA_W = 16;
    localparam int DACC_BUS_W = 32;
    localparam int DACC_NREG = 5;
    localparam int DACC_IDX_W = 6;
    localparam int DACC_R_CLOCK = 0;
    localparam int DACC_R_GAIN = 1;
    localparam int DACC_R_CHOP = 2;
    localparam int DACC_R_ROUTE0 = 3;
    localparam int DACC_R_ROUTE1 = 4;
    // Register indices; the byte address is four times the index
    localparam logic [5:0] DACC_IDX [DACC_NREG] = '{6'h03, 6'h04, 6'h06, 6'h09, 6'h0e};
    localparam logic [15:0] DACC_RST [DACC_NREG] = '{16'h038e, 16'h0000, 16'h0600, 16'h0000,
                                                   16'h0000};
    // Bits that software may change; all others read as zero
    localparam logic [15:0] DACC_WMASK [DACC_NREG] = '{16'h03ff, 16'hffff, 16'hffff, 16'hffc7,
                                                     16'hffc7};

    // ==================================================================
    // Field layout
    localparam int DACC_SECOND_EN_BIT = 9;
    localparam int DACC_FIRST_EN_BIT = 8;
    localparam int DACC_CLK_SEL_BIT = 7;
    localparam int DACC_OSR_LSB = 2;
    localparam int DACC_OSR_W = 3;
    localparam int DACC_PWR_LSB = 0;
    localparam int DACC_PWR_W = 2;
    localparam int DACC_PWR_HIRES_BIT = 1;
    localparam int DACC_GAIN1_LSB = 4;
    localparam int DACC_GAIN0_LSB = 0;
    localparam int DACC_GAIN_W = 3;
    localparam int DACC_DLY_LSB = 9;
    localparam int DACC_DLY_CODE_W = 4;
    localparam int DACC_CHOP_EN_BIT = 8;
    localparam int DACC_ROUTE_LSB = 0;
    localparam int DACC_ROUTE_W = 2;

    // ==================================================================
    // Decoded values and timing
    localparam logic [14:0] DACC_OSR_BASE = 15'h0080;
    localparam logic [7:0] DACC_GAIN_BASE = 8'h01;
    localparam int DACC_DLY_W = 14;
    localparam logic [13:0] DACC_DLY_BASE = 14'h0002;
    localparam logic [3:0] DACC_DLY_MAX_CODE = 4'hc;

    typedef enum logic [0:0] {
        DACC_ST_IDLE = 1'b0,
        DACC_ST_WAIT = 1'b1
    } dacc_settle_state_t;

endpackage

/* File: common/dacc_settle_if.sv */
// Carrier between the register block and its chop settle timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface dacc_settle_if;
    logic start;
    logic chop_on;
    logic [3:0] delay_code;
    logic busy;
    logic done;

    modport ctrl (output start, output chop_on, output delay_code, input busy, input done);
    modport timer (input start, input chop_on, input delay_code, output busy, output done);
endinterface

`default_nettype wire

/* File: hdl/dacc_settle_timer.sv */
// Chop settle timer: delays each measurement start by the selected period count while chop is on; with chop off it passes the start through.
// Assumes one clk cycle equals one modulator clock period.
`timescale 1ns/100ps
`default_nettype none

module dacc_settle_timer
    import dacc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    dacc_settle_if.timer bus
);

    // ==================================================================
    // Decode
    dacc_settle_state_t state_reg;
    dacc_settle_state_t state_next;
    logic [DACC_DLY_W-1:0] cnt_reg;
    logic [DACC_DLY_W-1:0] cnt_next;
    logic done_reg;
    logic [3:0] code_clamped;
    logic [DACC_DLY_W-1:0] load_val;
    logic accept;
    logic cnt_zero;

    // Codes past the last documented step hold at the longest delay
    assign code_clamped = (bus.delay_code > DACC_DLY_MAX_CODE) ? DACC_DLY_MAX_CODE : bus.delay_code;
    assign load_val = DACC_DLY_W'((DACC_DLY_BASE << code_clamped) - 14'h0001); // [R08]
    assign accept = bus.start && (state_reg == DACC_ST_IDLE);
    assign cnt_zero = (cnt_reg == '0);
    assign bus.busy = (state_reg == DACC_ST_WAIT);
    assign bus.done = done_reg;

    // Next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            DACC_ST_IDLE: if (accept && bus.chop_on) state_next = DACC_ST_WAIT; // [R09]
            DACC_ST_WAIT: if (cnt_zero) state_next = DACC_ST_IDLE;
            default: state_next = DACC_ST_IDLE;
        endcase
    end

    assign cnt_next = accept ? load_val : (bus.busy ? cnt_reg - 14'h0001 : cnt_reg);

    // Registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= DACC_ST_IDLE;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= (accept && !bus.chop_on) || (bus.busy && cnt_zero); // [R08] [R09]
        end
    end

    // ==================================================================
    // Checks
    logic [16:0] waited_reg;
    logic [16:0] expect_reg;

    // Helper: cycles spent waiting against the count latched at start
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            waited_reg <= '0;
            expect_reg <= '0;
        end
        else
        begin
            waited_reg <= accept ? 17'h0_0000 : (bus.busy ? waited_reg + 17'h0_0001 : waited_reg);
            expect_reg <= accept ? 17'({3'b000, load_val} + 17'h0_0001) : expect_reg;
        end
    end

    settle_length_a: assert property (@(posedge clk) disable iff (!resetn) // [R08]
        done_reg && $past(bus.busy) |-> waited_reg == expect_reg)
        else $error("settle wait length wrong");
    settle_short_a: assert property (@(posedge clk) disable iff (!resetn) // [R08]
        accept && bus.chop_on && bus.delay_code == 4'h0 |=> !done_reg ##1 !done_reg ##1 done_reg)
        else $error("shortest settle delay wrong");
    chop_off_a: assert property (@(posedge clk) disable iff (!resetn) // [R09]
        accept && !bus.chop_on |=> done_reg && !bus.busy)
        else $error("start not passed through with chop off");
    settle_cov_c: cover property (@(posedge clk) disable iff (!resetn)
        accept && bus.chop_on ##[1:20] done_reg);

endmodule

`default_nettype wire

/* File: hdl/dacc_cfg_top.sv */
// Configuration register set of a two-channel delta-sigma converter on Avalon-MM.
// Assumes a single clk, the modulator-derived clock, and one master on the bus.
//
// Functional notes
// R01 - Bit 9 enables second converter, resets on
// R02 - Bit 8 enables first converter, resets on
// R03 - Bit 7 picks external or internal clock
// R04 - Oversampling ratio is 128 shifted by code
// R05 - Power mode code; upper codes mean high resolution
// R06 - Gain bits 6:4 set second gain
// R07 - Gain bits 2:0 set first gain
// R08 - Chop waits selected doubling period count
// R09 - Chop setup bit 8 turns chop on
// R10 - First route bits 1:0 select input
// R11 - Second route bits 1:0 select input
// R12 - Clock setup register sits at index 03h
// R13 - Writes touch writable bits; reserved read zero
`timescale 1ns/100ps
`default_nettype none

module dacc_cfg_top
    import dacc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [DACC_BUS_W-1:0] writedata,
    output logic [DACC_BUS_W-1:0] readdata,
    output logic waitrequest,
    input wire logic meas_request,
    output logic meas_start,
    output logic settle_busy,
    output logic second_conv_enable,
    output logic first_conv_enable,
    output logic ext_clock_select,
    output logic [DACC_OSR_W-1:0] oversample_ratio_code,
    output logic [14:0] oversample_ratio,
    output logic [DACC_PWR_W-1:0] power_level_code,
    output logic high_res_mode,
    output logic [DACC_GAIN_W-1:0] second_amp_gain_code,
    output logic [DACC_GAIN_W-1:0] first_amp_gain_code,
    output logic [7:0] second_amp_gain,
    output logic [7:0] first_amp_gain,
    output logic chop_enable,
    output logic [DACC_DLY_CODE_W-1:0] chop_settle_delay_code,
    output logic [DACC_ROUTE_W-1:0] first_input_route_code,
    output logic [DACC_ROUTE_W-1:0] second_input_route_code
);

    // ==================================================================
    // Elaboration checks
    if (ADDR_W < DACC_IDX_W + 2)
    begin : g_addr_check
        $error("address too narrow for the register map");
    end

    // ==================================================================
    // Bus handshake
    logic ack_reg;
    logic ack_next;
    logic req;
    logic wr_fire;
    logic rd_capture;
    logic addr_ok;
    logic [ADDR_W-3:0] word_addr;
    logic [DACC_DATA_W-1:0] be_mask;
    logic [DACC_NREG-1:0] hit;
    logic [DACC_DATA_W-1:0] rd_word;
    logic [DACC_BUS_W-1:0] readdata_reg;
    logic [DACC_DATA_W-1:0] cfg_reg [DACC_NREG];
    logic [DACC_DATA_W-1:0] cfg_next [DACC_NREG];
    logic [DACC_DATA_W-1:0] rd_part [DACC_NREG];

    // One wait cycle per request; the write lands on the acknowledging edge
    assign req = read || write;
    assign ack_next = req && !ack_reg;
    assign waitrequest = req && !ack_reg;
    assign wr_fire = write && ack_reg;
    assign rd_capture = read && !ack_reg;
    assign readdata = readdata_reg;

    // Address decode: word aligned byte addresses only
    assign word_addr = address[ADDR_W-1:2];
    assign addr_ok = (address[1:0] == 2'b00);
    assign be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ack_reg <= 1'b0;
        else
            ack_reg <= ack_next;
    end

    // ==================================================================
    // Register storage, one entry per configuration word
    for (genvar i = 0; i < DACC_NREG; i++)
    begin : g_reg
        assign hit[i] = addr_ok && (word_addr == (ADDR_W-2)'(DACC_IDX[i])); // [R12]
        // Only writable bits in enabled lanes change
        assign cfg_next[i] = (cfg_reg[i] & ~(DACC_WMASK[i] & be_mask))
            | (writedata[DACC_DATA_W-1:0] & DACC_WMASK[i] & be_mask); // [R13]
        assign rd_part[i] = hit[i] ? (cfg_reg[i] & DACC_WMASK[i]) : '0; // [R13]

        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
                cfg_reg[i] <= DACC_RST[i];
            else if (wr_fire && hit[i])
                cfg_reg[i] <= cfg_next[i];
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb
    begin
        rd_word = '0;
        for (int k = 0; k < DACC_NREG; k++)
            rd_word = rd_word | rd_part[k];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            readdata_reg <= '0;
        else if (rd_capture)
            readdata_reg <= {{(DACC_BUS_W-DACC_DATA_W){1'b0}}, rd_word};
    end

    // ==================================================================
    // Field outputs
    assign second_conv_enable = cfg_reg[DACC_R_CLOCK][DACC_SECOND_EN_BIT]; // [R01]
    assign first_conv_enable = cfg_reg[DACC_R_CLOCK][DACC_FIRST_EN_BIT]; // [R02]
    assign ext_clock_select = cfg_reg[DACC_R_CLOCK][DACC_CLK_SEL_BIT]; // [R03]
    assign oversample_ratio_code = cfg_reg[DACC_R_CLOCK][DACC_OSR_LSB +: DACC_OSR_W]; // [R04]
    assign power_level_code = cfg_reg[DACC_R_CLOCK][DACC_PWR_LSB +: DACC_PWR_W]; // [R05]
    assign second_amp_gain_code = cfg_reg[DACC_R_GAIN][DACC_GAIN1_LSB +: DACC_GAIN_W]; // [R06]
    assign first_amp_gain_code = cfg_reg[DACC_R_GAIN][DACC_GAIN0_LSB +: DACC_GAIN_W]; // [R07]
    assign chop_enable = cfg_reg[DACC_R_CHOP][DACC_CHOP_EN_BIT]; // [R09]
    assign chop_settle_delay_code = cfg_reg[DACC_R_CHOP][DACC_DLY_LSB +: DACC_DLY_CODE_W];
    assign first_input_route_code = cfg_reg[DACC_R_ROUTE0][DACC_ROUTE_LSB +: DACC_ROUTE_W]; // [R10]
    assign second_input_route_code = cfg_reg[DACC_R_ROUTE1][DACC_ROUTE_LSB +: DACC_ROUTE_W]; // [R11]

    // Decoded ratio, gains and power mode, registered
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // Decoded copies start from the documented field defaults
            oversample_ratio <= DACC_OSR_BASE << DACC_RST[DACC_R_CLOCK][DACC_OSR_LSB +: DACC_OSR_W];
            high_res_mode <= DACC_RST[DACC_R_CLOCK][DACC_PWR_HIRES_BIT]; // [R05]
            second_amp_gain <= DACC_GAIN_BASE;
            first_amp_gain <= DACC_GAIN_BASE;
        end
        else
        begin
            oversample_ratio <= DACC_OSR_BASE << oversample_ratio_code; // [R04]
            high_res_mode <= power_level_code[DACC_PWR_HIRES_BIT]; // [R05]
            second_amp_gain <= DACC_GAIN_BASE << second_amp_gain_code; // [R06]
            first_amp_gain <= DACC_GAIN_BASE << first_amp_gain_code; // [R07]
        end
    end

    // ==================================================================
    // Chop settle timer
    dacc_settle_if settle_bus ();

    assign settle_bus.start = meas_request;
    assign settle_bus.chop_on = chop_enable; // [R09]
    assign settle_bus.delay_code = chop_settle_delay_code; // [R08]
    assign meas_start = settle_bus.done;
    assign settle_busy = settle_bus.busy;

    dacc_settle_timer u_settle (
        .clk(clk),
        .resetn(resetn),
        .bus(settle_bus)
    );

    // ==================================================================
    // Checks
    logic wr_clock;
    logic wr_gain;
    logic wr_route0;
    logic wr_route1;
    logic rd_done;

    assign wr_clock = wr_fire && hit[DACC_R_CLOCK];
    assign wr_gain = wr_fire && hit[DACC_R_GAIN];
    assign wr_route0 = wr_fire && hit[DACC_R_ROUTE0];
    assign wr_route1 = wr_fire && hit[DACC_R_ROUTE1];
    assign rd_done = read && !waitrequest;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    second_enable_a: assert property (wr_clock && byteenable[1] |=> // [R01]
        second_conv_enable == $past(writedata[9]))
        else $error("second converter enable not written");
    first_enable_a: assert property (wr_clock && byteenable[1] |=> // [R02]
        first_conv_enable == $past(writedata[8]))
        else $error("first converter enable not written");
    clock_select_a: assert property (wr_clock && byteenable[0] |=> // [R03]
        ext_clock_select == $past(writedata[7]))
        else $error("clock source select not written");
    osr_ratio_a: assert property (wr_clock && byteenable[0] |-> ##2 // [R04]
        oversample_ratio == (15'h0080 << $past(writedata[4:2], 2)))
        else $error("oversampling ratio wrong");
    power_mode_a: assert property (wr_clock && byteenable[0] |-> ##2 // [R05]
        high_res_mode == $past(writedata[1], 2) && power_level_code == $past(writedata[1:0], 2))
        else $error("power mode wrong");
    second_gain_a: assert property (wr_gain && byteenable[0] |-> ##2 // [R06]
        second_amp_gain == (8'h01 << $past(writedata[6:4], 2)))
        else $error("second gain wrong");
    first_gain_a: assert property (wr_gain && byteenable[0] |-> ##2 // [R07]
        first_amp_gain == (8'h01 << $past(writedata[2:0], 2)))
        else $error("first gain wrong");
    first_route_a: assert property (wr_route0 && byteenable[0] |=> // [R10]
        first_input_route_code == $past(writedata[1:0]))
        else $error("first route not written");
    second_route_a: assert property (wr_route1 && byteenable[0] |=> // [R11]
        second_input_route_code == $past(writedata[1:0]))
        else $error("second route not written");
    clock_addr_a: assert property (rd_done && address == 8'h0c |-> // [R12]
        readdata[9:0] == {second_conv_enable, first_conv_enable, ext_clock_select,
        cfg_reg[DACC_R_CLOCK][6:5], oversample_ratio_code, power_level_code})
        else $error("clock setup read at wrong address");
    reserved_zero_a: assert property (rd_done |-> readdata[31:16] == 16'h0000 && // [R13]
        (!hit[DACC_R_CLOCK] || readdata[15:10] == 6'h00) &&
        (!hit[DACC_R_ROUTE0] || readdata[5:3] == 3'h0))
        else $error("reserved bits not zero");
    wait_length_a: assert property (req && !ack_reg |-> waitrequest ##1 !waitrequest) // [R13]
        else $error("request not answered in one wait cycle");

    write_clock_c: cover property (wr_clock ##1 read [*1] ##1 rd_done);
    read_chop_c: cover property (rd_done && hit[DACC_R_CHOP]);
    chop_meas_c: cover property (chop_enable && meas_request ##[2:40] meas_start);

endmodule

`default_nettype wire

/* File: testbench/tb_dual_adc_channel_config.sv */
// Self-checking bench for the two-channel converter configuration block.
// Assumes the register block answers on Avalon-MM and one clk equals one modulator period.
`timescale 1ns/100ps
`default_nettype none

module tb_dual_adc_channel_config;

    // ==================================================================
    // Stimulus and observed signals
    logic clk;
    logic resetn;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic meas_request;
    logic meas_start;
    logic settle_busy;
    logic second_conv_enable;
    logic first_conv_enable;
    logic ext_clock_select;
    logic [2:0] oversample_ratio_code;
    logic [14:0] oversample_ratio;
    logic [1:0] power_level_code;
    logic high_res_mode;
    logic [2:0] second_amp_gain_code;
    logic [2:0] first_amp_gain_code;
    logic [7:0] second_amp_gain;
    logic [7:0] first_amp_gain;
    logic chop_enable;
    logic [3:0] chop_settle_delay_code;
    logic [1:0] first_input_route_code;
    logic [1:0] second_input_route_code;
    int error_cnt;
    int check_count;

    dacc_cfg_top #(.ADDR_W(8)) dut (
        .clk(clk), .resetn(resetn), .address(address), .byteenable(byteenable),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .meas_request(meas_request), .meas_start(meas_start),
        .settle_busy(settle_busy), .second_conv_enable(second_conv_enable),
        .first_conv_enable(first_conv_enable), .ext_clock_select(ext_clock_select),
        .oversample_ratio_code(oversample_ratio_code), .oversample_ratio(oversample_ratio),
        .power_level_code(power_level_code), .high_res_mode(high_res_mode),
        .second_amp_gain_code(second_amp_gain_code), .first_amp_gain_code(first_amp_gain_code),
        .second_amp_gain(second_amp_gain), .first_amp_gain(first_amp_gain),
        .chop_enable(chop_enable), .chop_settle_delay_code(chop_settle_delay_code),
        .first_input_route_code(first_input_route_code),
        .second_input_route_code(second_input_route_code)
    );

    // ==================================================================
    // Shared helpers
    // Compares with case equality so an unknown never matches
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low at a rising edge
    task bus_xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                  input logic [3:0] be, output logic [31:0] rdata);
        int n;
        logic w;
        n = 0;
        w = 1'b1;
        rdata = '0;
        @(posedge clk);
        address <= a;
        byteenable <= be;
        writedata <= {16'h0000, d};
        read <= ~wr;
        write <= wr;
        // Sampled at the rising edge, before that edge's updates land
        while (w !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            w = waitrequest;
            rdata = readdata;
            n++;
        end
        read <= 1'b0;
        write <= 1'b0;
        if (w !== 1'b0)
            chk("bus_answer", 32'h0000_0000, 32'h0000_0001);
    endtask

    task wr16(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        bus_xfer(1'b1, a, d, 4'hf, r);
    endtask

    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus_xfer(1'b0, a, 16'h0000, 4'hf, r);
        chk(what, exp, r);
    endtask

    // Lets field outputs and their decoded copies land before sampling
    task settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // ==================================================================
    // Scenarios
    task test_reset;
        settle;
        chk("second_en", 1'h1, second_conv_enable);
        chk("first_en", 1'h1, first_conv_enable);
        chk("ext_clk", 1'h1, ext_clock_select);
        chk("osr", 15'h0400, oversample_ratio);
        chk("pwr", 2'h2, power_level_code);
        chk("hires", 1'h1, high_res_mode);
        chk("gain1", 8'h01, second_amp_gain);
        chk("gain0", 8'h01, first_amp_gain);
        chk("dly", 4'h3, chop_settle_delay_code);
        chk("chop", 1'h0, chop_enable);
        chk("route0", 2'h0, first_input_route_code);
        chk("route1", 2'h0, second_input_route_code);
        rd_chk("clock_setup", 8'h0c, 32'h0000_038e);
        rd_chk("amp_gain", 8'h10, 32'h0000_0000);
        rd_chk("chop_setup", 8'h18, 32'h0000_0600);
        rd_chk("first_route", 8'h24, 32'h0000_0000);
        rd_chk("second_route", 8'h38, 32'h0000_0000);
        $display("test_reset done");
    endtask

    task test_clock;
        wr16(8'h0c, 16'hffff);
        rd_chk("clock_rsvd", 8'h0c, 32'h0000_03ff);
        wr16(8'h0c, 16'h0000);
        settle;
        chk("second_off", 1'h0, second_conv_enable);
        chk("first_off", 1'h0, first_conv_enable);
        chk("int_clk", 1'h0, ext_clock_select);
        for (int c = 0; c < 8; c++)
        begin
            wr16(8'h0c, 16'h0380 | 16'(c << 2) | 16'(c % 4));
            settle;
            chk("osr_code", 32'(c), oversample_ratio_code);
            chk("osr_val", 32'(128 << c), oversample_ratio);
            chk("pwr_code", 32'(c % 4), power_level_code);
            chk("hires_c", 32'((c % 4) >= 2), high_res_mode);
        end
        $display("test_clock done");
    endtask

    task test_gain;
        logic [31:0] r;
        for (int c = 0; c < 8; c++)
        begin
            wr16(8'h10, 16'((c << 4) | (7 - c)));
            settle;
            chk("gain1_code", 32'(c), second_amp_gain_code);
            chk("gain1_val", 32'(1 << c), second_amp_gain);
            chk("gain0_code", 32'(7 - c), first_amp_gain_code);
            chk("gain0_val", 32'(1 << (7 - c)), first_amp_gain);
        end
        bus_xfer(1'b1, 8'h10, 16'hab55, 4'h2, r);
        rd_chk("gain_lane", 8'h10, 32'h0000_ab70);
        $display("test_gain done");
    endtask

    task test_route;
        for (int c = 0; c < 4; c++)
        begin
            wr16(8'h24, 16'hfff8 | 16'(c));
            wr16(8'h38, 16'hfff8 | 16'(3 - c));
            settle;
            chk("route0_code", 32'(c), first_input_route_code);
            chk("route1_code", 32'(3 - c), second_input_route_code);
            rd_chk("route0_rd", 8'h24, 32'h0000_ffc0 | 32'(c));
            rd_chk("route1_rd", 8'h38, 32'h0000_ffc0 | 32'(3 - c));
        end
        wr16(8'h14, 16'hffff);
        rd_chk("unmapped", 8'h14, 32'h0000_0000);
        rd_chk("unaligned", 8'h25, 32'h0000_0000);
        rd_chk("route0_kept", 8'h24, 32'h0000_ffc3);
        $display("test_route done");
    endtask

    // A second request during the wait must be ignored
    task test_meas(input logic chop, input int code);
        int n;
        n = chop ? (2 << code) : 0;
        wr16(8'h18, 16'(code << 9) | (chop ? 16'h0100 : 16'h0000));
        settle;
        chk("chop_en", 32'(chop), chop_enable);
        chk("dly_code", 32'(code), chop_settle_delay_code);
        @(posedge clk);
        meas_request <= 1'b1;
        @(posedge clk);
        meas_request <= 1'b0;
        for (int k = 1; k <= n + 2; k++)
        begin
            @(negedge clk);
            chk("settle_busy", 32'(k <= n), settle_busy);
            chk("meas_start", 32'(k == n + 1), meas_start);
            @(posedge clk);
            meas_request <= (k == 1 && n > 0);
        end
        $display("test_meas done chop %0d code %0d", chop, code);
    endtask

    // ==================================================================
    // Verdict, clock, watchdog and main sequence
    task close_out;
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Longest run is the 8192-period wait plus a few hundred bus cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        $display("Error watchdog expected finish seen hang");
        close_out;
    end

    initial
    begin
        error_cnt = 0;
        check_count = 0;
        resetn = 1'b0;
        address = 8'h00;
        byteenable = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        meas_request = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        test_reset;
        test_clock;
        test_gain;
        test_route;
        test_meas(1'b0, 3);
        test_meas(1'b1, 0);
        test_meas(1'b1, 1);
        test_meas(1'b1, 3);
        test_meas(1'b1, 12);
        close_out;
    end

endmodule

`default_nettype wire
